// >>> shared/mid_pkg.sv
package mid_pkg;

	// ----------------------------------------------------------------
	// Instruction word layout
	// ----------------------------------------------------------------
	localparam int INSTR_W      = 14;
	localparam int FADDR_W      = 7;
	localparam int LIT_W        = 8;
	localparam int TGT_W        = 11;
	localparam int BIT_IDX_W    = 3;
	localparam int DATA_W       = 8;
	localparam int GROUP_MSB    = 13;
	localparam int GROUP_LSB    = 12;
	localparam int OPC_MSB      = 13;
	localparam int OPC_LSB      = 8;
	localparam int DEST_BIT     = 7;
	localparam int FADDR_MSB    = 6;
	localparam int BIT_MSB      = 9;
	localparam int BIT_LSB      = 7;
	localparam int BOP_MSB      = 11;
	localparam int BOP_LSB      = 10;
	localparam int GOTO_BIT     = 11;
	localparam int LOP_MSB      = 11;
	localparam int LOP_LSB      = 8;

	// Instruction groups in bits 13:12.
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT  = 2'h1;
	localparam logic [1:0] GRP_JUMP = 2'h2;
	localparam logic [1:0] GRP_LIT  = 2'h3;

	// Byte operation codes, bits 11:8.
	localparam logic [3:0] BOP_MISC  = 4'h0;
	localparam logic [3:0] BOP_CLR   = 4'h1;
	localparam logic [3:0] BOP_SUB   = 4'h2;
	localparam logic [3:0] BOP_DEC   = 4'h3;
	localparam logic [3:0] BOP_IOR   = 4'h4;
	localparam logic [3:0] BOP_AND   = 4'h5;
	localparam logic [3:0] BOP_XOR   = 4'h6;
	localparam logic [3:0] BOP_ADD   = 4'h7;
	localparam logic [3:0] BOP_MOV   = 4'h8;
	localparam logic [3:0] BOP_COM   = 4'h9;
	localparam logic [3:0] BOP_INC   = 4'hA;
	localparam logic [3:0] BOP_DECSZ = 4'hB;
	localparam logic [3:0] BOP_RRF   = 4'hC;
	localparam logic [3:0] BOP_RLF   = 4'hD;
	localparam logic [3:0] BOP_SWAP  = 4'hE;
	localparam logic [3:0] BOP_INCSZ = 4'hF;

	// Bit operation codes, bits 11:10.
	localparam logic [1:0] BIT_CLR   = 2'h0;
	localparam logic [1:0] BIT_SET   = 2'h1;
	localparam logic [1:0] BIT_TSTC  = 2'h2;

	// Control words of the misc group.
	localparam logic [7:0] CTL_RETURN = 8'h08;
	localparam logic [7:0] CTL_RETFIE = 8'h09;
	localparam logic [6:0] CTL_NOP    = 7'h00;
	localparam logic [7:0] CTL_NOP_MASK = 8'h9F;

	// Literal operation codes, bits 11:8 (don't-care bits masked).
	localparam logic [3:0] LOP_IOR  = 4'h8;
	localparam logic [3:0] LOP_AND  = 4'h9;
	localparam logic [3:0] LOP_XOR  = 4'hA;

	// Special register addresses.
	localparam logic [6:0] ADDR_TMR_CNT = 7'h01;
	localparam logic [6:0] ADDR_PORT2   = 7'h06;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int OSC_PER_CYCLE = 4;
	localparam int PH_W          = 2;
	localparam logic [1:0] PH_LAST = 2'(OSC_PER_CYCLE - 1);

	typedef enum logic [1:0] {
		MID_CLASS_BYTE,
		MID_CLASS_BIT,
		MID_CLASS_LIT
	} mid_class_t;

endpackage

// >>> hdl/mid_fetch_reg.sv
`timescale 1ns/1ps

// Instruction holding register; read data comes out of a flip-flop.
module mid_fetch_reg
	import mid_pkg::*;
(
	input  wire logic               clk_sys_i,
	input  wire logic               arst_n_i,
	input  wire logic               load_i,
	input  wire logic [INSTR_W-1:0] word_i,
	output logic      [INSTR_W-1:0] word_o
);

	// Latch a fresh word when asked; a reset holds a no-operation.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_o <= '0;
		end else if (load_i) begin
			word_o <= word_i;
		end
	end

endmodule // mid_fetch_reg

// >>> hdl/mid_decode.sv
`timescale 1ns/1ps

module mid_decode
	import mid_pkg::*;
(
	input  wire logic               clk_sys_i,
	input  wire logic               arst_n_i,
	input  wire logic [INSTR_W-1:0] prog_word_i,
	input  wire logic [DATA_W-1:0]  file_rdata_i,
	input  wire logic [DATA_W-1:0]  port_pins_i,
	input  wire logic               presc_on_timer_i,
	input  wire logic               carry_i,
	output logic                    fetch_o,
	output logic      [FADDR_W-1:0] file_addr_o,
	output logic                    file_rd_o,
	output logic                    file_we_o,
	output logic      [DATA_W-1:0]  file_wdata_o,
	output logic                    w_we_o,
	output logic      [DATA_W-1:0]  w_q_o,
	output logic                    pc_load_o,
	output logic      [TGT_W-1:0]   pc_target_o,
	output logic                    pc_pop_o,
	output logic                    pc_push_o,
	output logic                    port_mismatch_clr_o,
	output logic                    presc_clr_o,
	output logic      [1:0]         instr_class_o,
	output logic                    flush_o
);

	// ----------------------------------------------------------------
	// Cycle phase and fetch
	// ----------------------------------------------------------------
	logic [PH_W-1:0]    phase_q;
	logic               flush_q;
	logic [INSTR_W-1:0] ir;
	logic               last_ph;

	assign last_ph = (phase_q == PH_LAST);

	// Four clocks make one instruction cycle.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_q <= '0;
		end else begin
			phase_q <= phase_q + 2'(1);
		end
	end

	// Whole 14-bit word latched at the cycle boundary.
	mid_fetch_reg u_fetch (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.load_i    (last_ph),
		.word_i    (prog_word_i),
		.word_o    (ir)
	);

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	logic [1:0]           grp;
	logic [3:0]           bop;
	logic                 dest;
	logic [FADDR_W-1:0]   fa;
	logic [BIT_IDX_W-1:0] bidx;
	logic [1:0]           bitop;
	logic [LIT_W-1:0]     lit;
	logic [TGT_W-1:0]     tgt;
	mid_class_t           cls;

	assign grp   = ir[GROUP_MSB:GROUP_LSB];
	assign bop   = ir[OPC_MSB-2:OPC_LSB];
	assign dest  = ir[DEST_BIT];
	assign fa    = ir[FADDR_MSB:0];
	assign bidx  = ir[BIT_MSB:BIT_LSB];
	assign bitop = ir[BOP_MSB:BOP_LSB];
	assign lit   = ir[LIT_W-1:0];
	assign tgt   = ir[TGT_W-1:0];

	// Exactly one group per word; jumps join literal/control.
	always_comb begin
		unique case (grp)
			GRP_BYTE: cls = MID_CLASS_BYTE;
			GRP_BIT:  cls = MID_CLASS_BIT;
			GRP_JUMP,
			GRP_LIT:  cls = MID_CLASS_LIT;
		endcase
	end

	// ----------------------------------------------------------------
	// Execute
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] w_q;
	logic [DATA_W-1:0] src;
	logic [DATA_W-1:0] res;
	logic [DATA_W-1:0] bmask;
	logic              to_file;
	logic              to_w;
	logic              skip;
	logic              jump;
	logic              ret;
	logic              call;
	logic              names_file;
	logic              is_io;

	// Self-modify of an I/O port reads the pins.
	assign is_io = (fa == ADDR_PORT2);
	assign src   = is_io ? port_pins_i : file_rdata_i;
	assign bmask = DATA_W'(1) << bidx;

	// Compute result, destination and flow change.
	always_comb begin
		res        = '0;
		to_file    = 1'b0;
		to_w       = 1'b0;
		skip       = 1'b0;
		jump       = 1'b0;
		ret        = 1'b0;
		call       = 1'b0;
		names_file = 1'b0;
		unique case (cls)
			MID_CLASS_BYTE: begin
				names_file = 1'b1;
				to_file = dest;
				to_w    = !dest;
				unique case (bop)
					BOP_MISC: begin
						to_w = 1'b0;
						to_file = dest;
						res = w_q;
						names_file = dest;
						// Bits 6:5 of a no-operation are don't-care.
						if (ir[LIT_W-1:0] == CTL_RETURN) begin
							ret = 1'b1;
						end else if (ir[LIT_W-1:0] == CTL_RETFIE) begin
							ret = 1'b1;
						end
					end
					BOP_CLR:   res = '0;
					BOP_SUB:   res = src - w_q;
					BOP_DEC:   res = src - DATA_W'(1);
					BOP_IOR:   res = src | w_q;
					BOP_AND:   res = src & w_q;
					BOP_XOR:   res = src ^ w_q;
					BOP_ADD:   res = src + w_q;
					BOP_MOV:   res = src;
					BOP_COM:   res = ~src;
					BOP_INC:   res = src + DATA_W'(1);
					BOP_DECSZ: begin
						res  = src - DATA_W'(1);
						skip = (res == '0);
					end
					BOP_RRF:   res = {carry_i, src[DATA_W-1:1]};
					BOP_RLF:   res = {src[DATA_W-2:0], carry_i};
					BOP_SWAP:  res = {src[3:0], src[7:4]};
					BOP_INCSZ: begin
						res  = src + DATA_W'(1);
						skip = (res == '0);
					end
				endcase
				// Clear of W (d=0) ignores the file field.
				if (bop == BOP_CLR && !dest) begin
					names_file = 1'b0;
				end
			end
			MID_CLASS_BIT: begin
				names_file = 1'b1;
				unique case (bitop)
					BIT_CLR: begin
						res = src & ~bmask;
						to_file = 1'b1;
					end
					BIT_SET: begin
						res = src | bmask;
						to_file = 1'b1;
					end
					BIT_TSTC: skip = ((src & bmask) == '0);
					default:  skip = ((src & bmask) != '0);
				endcase
			end
			MID_CLASS_LIT: begin
				to_w = 1'b1;
				if (grp == GRP_JUMP) begin
					to_w = 1'b0;
					jump = 1'b1;
					call = !ir[GOTO_BIT];
				end else if (ir[LOP_MSB:LOP_MSB-1] == 2'h0) begin
					res = lit;
				end else if (ir[LOP_MSB:LOP_MSB-1] == 2'h1) begin
					res = lit;
					ret = 1'b1;
				end else if (ir[LOP_MSB:LOP_MSB-1] == 2'h2) begin
					unique case (ir[LOP_LSB+1:LOP_LSB])
						2'h0:    res = lit | w_q;
						2'h1:    res = lit & w_q;
						2'h2:    res = lit ^ w_q;
						default: res = '0;
					endcase
				end else if (!ir[LOP_LSB+1]) begin
					res = lit - w_q;
				end else begin
					res = lit + w_q;
				end
			end
			default: res = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// Cycle sequencing and outputs
	// ----------------------------------------------------------------
	logic exec;
	assign exec = (phase_q == '0) && !flush_q;

	// A taken flow change voids the next cycle as a no-op.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flush_q <= 1'b0;
		end else if (phase_q == '0) begin
			flush_q <= !flush_q && (skip || jump || ret);
		end
	end

	// Working register update.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w_q <= '0;
		end else if (exec && to_w) begin
			w_q <= res;
		end
	end

	// Register-file and flow strobes, one clock each; flush_o holds for four.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			file_addr_o         <= '0;
			file_rd_o           <= 1'b0;
			file_we_o           <= 1'b0;
			file_wdata_o        <= '0;
			w_we_o              <= 1'b0;
			pc_load_o           <= 1'b0;
			pc_target_o         <= '0;
			pc_pop_o            <= 1'b0;
			pc_push_o           <= 1'b0;
			port_mismatch_clr_o <= 1'b0;
			presc_clr_o         <= 1'b0;
			instr_class_o       <= '0;
			flush_o             <= 1'b0;
			fetch_o             <= 1'b0;
		end else begin
			file_addr_o   <= fa;
			file_rd_o     <= exec && names_file;
			file_we_o     <= exec && to_file;
			file_wdata_o  <= res;
			w_we_o        <= exec && to_w;
			pc_load_o     <= exec && jump;
			pc_target_o   <= tgt;
			pc_pop_o      <= exec && ret;
			pc_push_o     <= exec && call;
			instr_class_o <= 2'(cls);
			flush_o       <= flush_q;
			fetch_o       <= last_ph;
			// The implied read of the port clears its mismatch.
			port_mismatch_clr_o <= exec && names_file && is_io;
			presc_clr_o <= exec && to_file && (fa == ADDR_TMR_CNT)
				&& presc_on_timer_i;
		end
	end

	assign w_q_o = w_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	cycle_len_a: assert property (fetch_o |-> ##4 fetch_o)
		else $error("instruction cycle is not four clocks");
	flush_two_a: assert property (flush_q && phase_q == '0 |=>
		!file_we_o && !w_we_o)
		else $error("voided cycle performed a write");
	rmw_read_a: assert property (file_we_o |-> file_rd_o)
		else $error("file write without its read");
	port_clr_a: assert property (port_mismatch_clr_o |->
		file_addr_o == ADDR_PORT2 && file_rd_o)
		else $error("mismatch clear on wrong address");
	presc_clr_a: assert property (presc_clr_o |->
		file_we_o && file_addr_o == ADDR_TMR_CNT)
		else $error("prescaler clear without timer write");
	dest_sel_a: assert property (file_we_o && instr_class_o ==
		2'(MID_CLASS_BYTE) |-> !w_we_o)
		else $error("byte op wrote both W and file");
	one_group_a: assert property (instr_class_o != 2'h3)
		else $error("instruction fell into no group");
	jump_class_a: assert property (pc_load_o |->
		instr_class_o == 2'(MID_CLASS_LIT))
		else $error("jump strobe outside the control group");
	jump_skip_a: assert property (pc_load_o |=> ##3 flush_o)
		else $error("jump not followed by a voided cycle");

	cov_jump_c:  cover property (pc_load_o);
	cov_skip_c:  cover property (flush_o && !pc_load_o);
	cov_port_c:  cover property (port_mismatch_clr_o);
	cov_presc_c: cover property (presc_clr_o);

endmodule // mid_decode

// >>> test/mid_prog_mem.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Program memory model
// ------------------------------------------------------------
module mid_prog_mem
	import mid_pkg::*;
(
	input  wire logic               clk_sys_i,
	input  wire logic               arst_n_i,
	input  wire logic               fetch_i,
	output logic      [INSTR_W-1:0] word_o
);
	logic [INSTR_W-1:0] mem [16];
	logic [3:0]         idx_q;

	// Steps on by one whole word per fetch, on the falling edge.
	always @(negedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i)
			idx_q <= 4'h0;
		else if (fetch_i)
			idx_q <= idx_q + 4'h1;
	end

	// The addressed word is always presented.
	assign word_o = mem[idx_q];
endmodule // mid_prog_mem

// >>> test/mid_decode_tb.sv
`timescale 1ns/1ps

module mid_decode_tb
	import mid_pkg::*;
;
	logic               clk_sys_i, arst_n_i, presc, carry;
	logic [INSTR_W-1:0] word;
	logic [7:0]         fval, pins, fdata, wdata, w_q;
	logic [6:0]         faddr, addr;
	logic [10:0]        tgt, ptgt;
	logic [1:0]         cls, icls;
	logic               fetch, rd, we, wwe, load, pop, push, mis, psc, fl;
	integer n_rd, n_we, n_wwe, n_ld, n_pop, n_push, n_mis, n_psc, n_fl;
	int cyc, last_f, gap, num_errors, n_tests;

	// ------------------------------------------------------------
	// Clock, design and program memory
	// ------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	mid_decode i_mid_decode (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.prog_word_i(word), .file_rdata_i(fval), .port_pins_i(pins),
		.presc_on_timer_i(presc), .carry_i(carry), .fetch_o(fetch),
		.file_addr_o(addr), .file_rd_o(rd), .file_we_o(we),
		.file_wdata_o(wdata), .w_we_o(wwe), .w_q_o(w_q), .pc_load_o(load),
		.pc_target_o(ptgt), .pc_pop_o(pop), .pc_push_o(push),
		.port_mismatch_clr_o(mis), .presc_clr_o(psc),
		.instr_class_o(icls), .flush_o(fl));

	mid_prog_mem i_mid_prog_mem (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .fetch_i(fetch), .word_o(word));

	// Counts strobes and keeps what they carried, on settled values.
	always @(negedge clk_sys_i) begin
		cyc++;
		if (fetch) begin
			gap = cyc - last_f;
			last_f = cyc;
		end
		n_rd += rd;
		n_mis += mis;
		n_psc += psc;
		n_fl += fl;
		n_pop += pop;
		n_push += push;
		n_wwe += wwe;
		n_we += we;
		n_ld += load;
		if (we) begin
			faddr = addr;
			fdata = wdata;
		end
		if (load)
			tgt = ptgt;
		if (we || wwe)
			cls = icls;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk_val(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_cnt(input string nm, input integer e, g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// Resets the design, loads three words and lets them run out.
	task automatic run(input logic [13:0] w0, w1, w2, input logic [7:0] fv);
		arst_n_i = 1'b0;
		fval = fv;
		i_mid_prog_mem.mem[0] = w0;
		i_mid_prog_mem.mem[1] = w1;
		i_mid_prog_mem.mem[2] = w2;
		{n_rd, n_we, n_wwe, n_ld, n_pop, n_push} = '0;
		{n_mis, n_psc, n_fl} = '0;
		// Unknown captures keep a missing strobe from passing on old data.
		{faddr, fdata, tgt, cls} = 'x;
		repeat (20) @(negedge clk_sys_i);
		arst_n_i = 1'b1;
		repeat (26) @(negedge clk_sys_i);
	endtask

	task automatic print_verdict();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_byte();
		run(14'h0AA5, 14'h0, 14'h0, 8'h41);
		chk_val("faddr", 16'h25, faddr);
		chk_val("fdata", 16'h42, fdata);
		chk_cnt("w_we", 0, n_wwe);
		chk_cnt("rd", 1, n_rd > 0);
		chk_val("class", MID_CLASS_BYTE, cls);
		chk_cnt("gap", OSC_PER_CYCLE, gap);
		run(14'h0A25, 14'h0, 14'h0, 8'h41);
		chk_val("w", 16'h42, w_q);
		chk_cnt("f_we", 0, n_we);
	endtask

	task automatic t_port();
		pins = 8'h0F;
		run(14'h0186, 14'h0, 14'h0, 8'h33);
		chk_val("clr", 16'h0, fdata);
		chk_cnt("mis", 1, n_mis);
		chk_cnt("rd", 1, n_rd > 0);
		run(14'h0986, 14'h0, 14'h0, 8'hFF);
		chk_val("com", 16'hF0, fdata);
		presc = 1'b1;
		run(14'h0081, 14'h0082, 14'h0, 8'h0);
		chk_cnt("psc", 1, n_psc);
		presc = 1'b0;
		run(14'h0081, 14'h0, 14'h0, 8'h0);
		chk_cnt("psc", 0, n_psc);
	endtask

	task automatic t_bits();
		for (int b = 0; b < 8; b++) begin
			run({2'b01, BIT_SET, 3'(b), 7'h10}, 14'h0, 14'h0, 8'h00);
			chk_val("bsf", 16'(8'h1 << b), fdata);
			chk_val("class", MID_CLASS_BIT, cls);
			run({2'b01, BIT_CLR, 3'(b), 7'h10}, 14'h0, 14'h0, 8'hFF);
			chk_val("bcf", {8'h00, ~(8'h1 << b)}, fdata);
		end
		carry = 1'b1;
		run(14'h0CB0, 14'h0, 14'h0, 8'h02);
		chk_val("rrf", 16'h81, fdata);
		run(14'h0DB0, 14'h0, 14'h0, 8'h80);
		chk_val("rlf", 16'h01, fdata);
	endtask

	task automatic t_lit();
		logic [13:0] op [3] = '{14'h38A0, 14'h393C, 14'h3AFF};
		logic [7:0]  ex [3] = '{8'hAF, 8'h0C, 8'hF0};
		for (int i = 0; i < 6; i++) begin
			run((i < 3) ? 14'h300F : 14'h330F, op[i % 3], 14'h0, 8'h0);
			chk_val("w", ex[i % 3], w_q);
			chk_val("class", MID_CLASS_LIT, cls);
		end
	endtask

	task automatic t_flow();
		run(14'h2DA5, 14'h3011, 14'h3022, 8'h0);
		chk_val("goto", 16'h5A5, tgt);
		chk_cnt("load", 1, n_ld);
		chk_val("w", 16'h22, w_q);
		chk_cnt("w_we", 1, n_wwe);
		chk_cnt("flush", 1, n_fl > 0);
		run(14'h2123, 14'h0, 14'h0, 8'h0);
		chk_val("call", 16'h123, tgt);
		chk_cnt("load", 1, n_ld);
		chk_cnt("push", 1, n_push);
		run(14'h0008, 14'h3011, 14'h0, 8'h0);
		chk_cnt("pop", 1, n_pop);
		chk_cnt("w_we", 0, n_wwe);
		run(14'h3477, 14'h3011, 14'h0, 8'h0);
		chk_val("retlw", 16'h77, w_q);
	endtask

	task automatic t_skip();
		run(14'h1D90, 14'h3011, 14'h3022, 8'h08);
		chk_cnt("w_we", 1, n_wwe);
		chk_cnt("flush", 1, n_fl > 0);
		run(14'h1D90, 14'h3011, 14'h3022, 8'h00);
		chk_cnt("w_we", 2, n_wwe);
		chk_cnt("flush", 0, n_fl);
		run(14'h0BA0, 14'h3011, 14'h3022, 8'h01);
		chk_val("dec", 16'h00, fdata);
		chk_cnt("w_we", 1, n_wwe);
	endtask

	// Byte and literal arithmetic into W, then the remaining skips and a RETFIE.
	task automatic t_alu();
		logic [13:0] op [13] = '{14'h0220, 14'h0320, 14'h0420,
			14'h0520, 14'h0620, 14'h0720, 14'h0820, 14'h0E20,
			14'h0125, 14'h3C3C, 14'h3D3C, 14'h3E3C, 14'h3F3C};
		logic [7:0]  ex [13] = '{8'h2D, 8'h3B, 8'h3F, 8'h0C,
			8'h33, 8'h4B, 8'h3C, 8'hC3, 8'h00, 8'h2D, 8'h2D,
			8'h4B, 8'h4B};
		for (int i = 0; i < 13; i++) begin
			run(14'h300F, op[i], 14'h0, 8'h3C);
			chk_val("alu", ex[i], w_q);
		end
		run(14'h300F, 14'h0F20, 14'h3011, 8'hFF);
		chk_val("incsz", 16'h00, w_q);
		chk_cnt("w_we", 2, n_wwe);
		run(14'h1820, 14'h3011, 14'h3022, 8'h00);
		chk_val("btfsc", 16'h22, w_q);
		chk_cnt("w_we", 1, n_wwe);
		run(14'h0009, 14'h3011, 14'h0, 8'h00);
		chk_cnt("pop", 1, n_pop);
		chk_cnt("w_we", 0, n_wwe);
	endtask

	// Main sequence; every input has a value at time zero.
	initial begin
		{arst_n_i, presc, carry, fval, pins} = '0;
		{cyc, last_f, gap, num_errors, n_tests} = '0;
		for (int i = 0; i < 16; i++)
			i_mid_prog_mem.mem[i] = 14'h0;
		@(negedge clk_sys_i);
		t_byte();
		t_port();
		t_bits();
		t_lit();
		t_flow();
		t_skip();
		t_alu();
		print_verdict();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#(50 * 8000);
		num_errors++;
		print_verdict();
	end
endmodule // mid_decode_tb
